// File: logic/ssle_pkg.sv
// Constants, types and helpers for the shading and streak erase stage.
// Assumes one clock domain; included by every design file of the block.
package ssle_pkg;

  // Line layout and black reference
  localparam int          DUMMY_PIX   = 32;
  localparam int          DUMMY_SHIFT = 5;
  localparam int          ACC_W       = 13;

  // Shading limits and output range
  localparam logic [7:0]  LAMP_MIN_PEAK = 8'h40;
  localparam logic [5:0]  PIX_TOP       = 6'h3f;
  localparam logic [2:0]  DENS_MID      = 3'h4;

  // Register offsets
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_MODE   = 4'h1;
  localparam logic [3:0]  REG_STREAK = 4'h2;
  localparam logic [3:0]  REG_STATUS = 4'h3;
  localparam logic [3:0]  REG_MASK   = 4'h4;
  localparam logic [3:0]  REG_STATE  = 4'h5;
  localparam logic [3:0]  REG_BLACK  = 4'h6;
  localparam logic [3:0]  REG_PEAK   = 4'h7;
  localparam logic [3:0]  REG_BG     = 4'h8;

  // Field positions
  localparam int CTRL_JOB_START  = 0;
  localparam int CTRL_PAGE_START = 1;
  localparam int CTRL_PAGE_DONE  = 2;
  localparam int CTRL_JOB_END    = 3;
  localparam int MODE_LSB        = 0;
  localparam int DENS_LSB        = 4;
  localparam int ADS_EN_BIT      = 7;
  localparam int WHITE_LVL_LSB   = 0;
  localparam int BLACK_LVL_LSB   = 2;
  localparam int ST_SHADE_DONE   = 0;
  localparam int ST_LAMP         = 1;
  localparam int ST_LINE         = 2;

  // Values after reset
  localparam logic [7:0] MODE_RST   = 8'hc0;
  localparam logic [7:0] STREAK_RST = 8'h05;

  // Streak thresholds and widths
  localparam logic [5:0] WHITE_THR1 = 6'h10;
  localparam logic [5:0] WHITE_THR2 = 6'h08;
  localparam logic [5:0] BLACK_THR1 = 6'h18;
  localparam logic [5:0] BLACK_THR2 = 6'h10;
  localparam logic [5:0] BLACK_THR3 = 6'h08;
  localparam int         WHITE_MAX_W  = 6;
  localparam int         BLACK_MAX_W12 = 4;
  localparam int         BLACK_MAX_W3  = 6;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SHADE = 3'b001,
    ST_READY = 3'b010,
    ST_SCAN  = 3'b011,
    ST_FAULT = 3'b100
  } ssle_state_t;

  typedef enum logic [3:0] {
    MD_NORMAL = 4'h0, MD_SHARP = 4'h1, MD_PHOTO_PRI = 4'h2, MD_TEXT_PRI = 4'h3,
    MD_PHOTOS = 4'h4, MD_UNNEEDED_BG = 4'h5, MD_COLOR_TEXT = 4'h6,
    MD_NORMAL_PIX = 4'h7, MD_COARSE_PIX = 4'h8, MD_PRESERVED_BG = 4'h9
  } ssle_mode_t;

  // Scale a so that b maps to the top code
  function automatic logic [5:0] ssle_scale(input logic [5:0] a, input logic [5:0] b);
    logic [11:0] p;
    p = 12'(a) * 12'(PIX_TOP);
    if (b == 6'h00) return PIX_TOP;
    p = p / 12'(b);
    return (p > 12'(PIX_TOP)) ? PIX_TOP : p[5:0];
  endfunction

endpackage

// File: logic/ssle_shading_top.sv
// Black and white shading, lamp check, streak erase and background tracking.
// Assumes an 8-bit sensor stream from outside the clock domain and a
// same-clock register port; one clock, asynchronous active-low reset.
`timescale 1ns/1ps

// Contract
// - Average 32 dummy pixels as black reference
// - Black and white correction always applied
// - White correction works on 6-bit data
// - Store per-pixel white plate average before scanning
// - White peak at most 64 raises lamp fault
// - Shade before first page and after each
// - Mode or density change forces fresh shading
// - White streak erase on when level nonzero
// - Lighter pixels replaced from neighbouring densities
// - Only white streaks one to six wide
// - Level two also erases less-white streaks
// - Black streak erase on when level nonzero
// - Higher black level erases fainter streaks
// - Black width four at 1-2, six at 3
// - Per-line peak white is background reference
// - Background and manual density both applied
// - Background tracking only in text modes
module ssle_shading_top import ssle_pkg::*; #(
  parameter int LINE_PIX    = 256,
  parameter int SHADE_LINES = 4
) (
  input  wire logic       I_MCLK,
  input  wire logic       I_NRST,
  input  wire logic       I_PIX_VALID,
  input  wire logic       I_LINE_SYNC,
  input  wire logic [7:0] I_PIX,
  input  wire logic [3:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  output logic      [7:0] O_RDATA,
  output logic            O_IRQ,
  output logic            O_PIX_VALID,
  output logic      [5:0] O_PIX,
  output logic      [5:0] O_BG_LEVEL,
  output logic            O_LAMP_FAULT
);

  localparam int CW = $clog2(DUMMY_PIX + LINE_PIX + 1);
  localparam int IW = $clog2(LINE_PIX);
  localparam int SW = $clog2(SHADE_LINES + 1);
  localparam logic [CW-1:0] DUM_END   = CW'(DUMMY_PIX);
  localparam logic [CW-1:0] IMG_END   = CW'(DUMMY_PIX + LINE_PIX);
  localparam logic [SW-1:0] SHADE_END = SW'(SHADE_LINES);

  generate
    if (LINE_PIX < 2 || SHADE_LINES < 1) begin : g_chk
      $error("ssle_shading_top needs LINE_PIX >= 2 and SHADE_LINES >= 1");
    end
  endgenerate

  typedef struct packed {
    logic                     s1_v;
    logic                     s1_l;
    logic [7:0]               s1_p;
    logic                     s2_v;
    logic                     s2_l;
    logic [7:0]               s2_p;
    ssle_state_t              st;
    logic [7:0]               mode_reg;
    logic [7:0]               streak_reg;
    logic [7:0]               status;
    logic [7:0]               mask;
    logic [7:0]               rdata;
    logic [CW-1:0]            cnt;
    logic [ACC_W-1:0]         acc;
    logic [7:0]               black;
    logic                     armed;
    logic [SW-1:0]            shade_lines;
    logic [7:0]               shade_peak;
    logic [LINE_PIX-1:0][5:0] white;
    logic                     norm_v;
    logic                     norm_eol;
    logic [5:0]               norm;
    logic [5:0]               line_peak;
    logic [5:0]               bg;
    logic                     adj_v;
    logic [5:0]               adj;
  } ssle_regs_t;

  ssle_regs_t       q;
  ssle_regs_t       next_q;
  logic [CW-1:0]    cur;
  logic             in_img;
  logic             eol;
  logic [IW-1:0]    idx;
  logic [7:0]       corr;
  logic [5:0]       pix6;
  logic [ACC_W-1:0] acc_new;
  logic [5:0]       peak_new;
  logic [5:0]       ads_pix;
  logic             ads_act;
  logic             start_shade;
  logic             shade_end;
  logic [7:0]       ev;
  logic [7:0]       clr;

  // Modes in which background tracking may run
  function automatic logic ssle_ads_mode(input logic [3:0] m);
    return m == MD_NORMAL || m == MD_SHARP || m == MD_TEXT_PRI ||
           m == MD_UNNEEDED_BG || m == MD_COLOR_TEXT;
  endfunction

  // Manual density as a saturating offset around the middle setting
  function automatic logic [5:0] ssle_density(input logic [5:0] v, input logic [2:0] d);
    logic [7:0] s;
    s = 8'(v) + 8'(d) - 8'(DENS_MID);
    if (s[7]) return 6'h00;
    return (s > 8'(PIX_TOP)) ? PIX_TOP : s[5:0];
  endfunction

  // Whole datapath, sequencer and register port
  always_comb begin
    next_q = q;
    ev = '0;
    clr = '0;
    start_shade = 1'b0;
    cur = q.s2_l ? '0 : q.cnt;
    in_img = (cur >= DUM_END) && (cur < IMG_END);
    eol = in_img && (cur == IMG_END - 1'b1);
    idx = IW'(cur - DUM_END);
    corr = (q.s2_p > q.black) ? q.s2_p - q.black : 8'h00;
    pix6 = corr[7:2];
    acc_new = (q.s2_l ? '0 : q.acc) + ACC_W'(q.s2_p);
    peak_new = (q.norm > q.line_peak) ? q.norm : q.line_peak;
    ads_act = q.mode_reg[ADS_EN_BIT] && ssle_ads_mode(q.mode_reg[MODE_LSB +: 4]);
    ads_pix = (ads_act && q.bg != 6'h00) ? ssle_scale(q.norm, q.bg) : q.norm;
    shade_end = (q.st == ST_SHADE) && (q.shade_lines == SHADE_END);

    // Two-stage synchronisers on the sensor pins
    next_q.s1_v = I_PIX_VALID;
    next_q.s1_l = I_LINE_SYNC;
    next_q.s1_p = I_PIX;
    next_q.s2_v = q.s1_v;
    next_q.s2_l = q.s1_l;
    next_q.s2_p = q.s1_p;
    next_q.norm_v = 1'b0;
    next_q.adj_v = 1'b0;

    // Line position and dummy pixel sum
    if (q.s2_v) begin
      next_q.cnt = (cur == IMG_END) ? cur : cur + 1'b1;
      if (cur < DUM_END) begin
        next_q.acc = acc_new;
        if (cur == DUM_END - 1'b1) begin
          next_q.black = 8'(acc_new >> DUMMY_SHIFT);
        end
      end
    end

    // White plate capture, averaged over the shading lines
    if (q.st == ST_SHADE && q.s2_v && !shade_end) begin
      if (q.s2_l) next_q.armed = 1'b1;
      if (in_img && q.armed) begin
        if (corr > q.shade_peak) next_q.shade_peak = corr;
        next_q.white[idx] = (q.shade_lines == '0) ? pix6 :
                            6'((7'(q.white[idx]) + 7'(pix6) + 7'h01) >> 1);
        if (eol) next_q.shade_lines = q.shade_lines + 1'b1;
      end
    end

    // End of shading: lamp check
    if (shade_end) begin
      if (q.shade_peak <= LAMP_MIN_PEAK) begin
        next_q.st = ST_FAULT;
        ev[ST_LAMP] = 1'b1;
      end else begin
        next_q.st = ST_READY;
        ev[ST_SHADE_DONE] = 1'b1;
      end
    end

    // Page scan: white normalisation of every image pixel
    if (q.st == ST_SCAN && q.s2_v && in_img) begin
      next_q.norm_v = 1'b1;
      next_q.norm = ssle_scale(pix6, q.white[idx]);
      next_q.norm_eol = eol;
    end

    // Peak white per line, background and manual density
    if (q.norm_v) begin
      next_q.line_peak = q.norm_eol ? 6'h00 : peak_new;
      if (q.norm_eol) begin
        next_q.bg = peak_new;
        ev[ST_LINE] = 1'b1;
      end
      next_q.adj_v = 1'b1;
      next_q.adj = ssle_density(ads_pix, q.mode_reg[DENS_LSB +: 3]);
    end

    // Register writes and sequencing commands
    if (I_WR) begin
      if (I_ADDR == REG_CTRL) begin
        if (I_WDATA[CTRL_JOB_START] && (q.st == ST_IDLE || q.st == ST_FAULT)) start_shade = 1'b1;
        if (I_WDATA[CTRL_PAGE_START] && q.st == ST_READY) next_q.st = ST_SCAN;
        if (I_WDATA[CTRL_PAGE_DONE] && q.st == ST_SCAN) start_shade = 1'b1;
      end else if (I_ADDR == REG_MODE) begin
        next_q.mode_reg = I_WDATA;
        if (q.st == ST_READY && I_WDATA != q.mode_reg) start_shade = 1'b1;
      end else if (I_ADDR == REG_STREAK) begin
        next_q.streak_reg = I_WDATA;
      end else if (I_ADDR == REG_MASK) begin
        next_q.mask = I_WDATA;
      end
    end
    if (start_shade) begin
      next_q.st = ST_SHADE;
      next_q.armed = 1'b0;
      next_q.shade_lines = '0;
      next_q.shade_peak = 8'h00;
    end
    if (I_WR && I_ADDR == REG_CTRL && I_WDATA[CTRL_JOB_END]) next_q.st = ST_IDLE;

    // Register reads, one cycle later
    next_q.rdata = 8'h00;
    if (I_RD) begin
      if (I_ADDR == REG_MODE) begin
        next_q.rdata = q.mode_reg;
      end else if (I_ADDR == REG_STREAK) begin
        next_q.rdata = q.streak_reg;
      end else if (I_ADDR == REG_STATUS) begin
        next_q.rdata = q.status;
        clr = 8'hff;
      end else if (I_ADDR == REG_MASK) begin
        next_q.rdata = q.mask;
      end else if (I_ADDR == REG_STATE) begin
        next_q.rdata = {5'h00, q.st};
      end else if (I_ADDR == REG_BLACK) begin
        next_q.rdata = q.black;
      end else if (I_ADDR == REG_PEAK) begin
        next_q.rdata = q.shade_peak;
      end else if (I_ADDR == REG_BG) begin
        next_q.rdata = {2'h0, q.bg};
      end
    end
    // New events win over a clearing read
    next_q.status = (q.status & ~clr) | ev;
  end

  // State register
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.mode_reg <= MODE_RST;
      q.streak_reg <= STREAK_RST;
    end else begin
      q <= next_q;
    end
  end

  // Streak erase on the corrected stream
  ssle_streak_filter #(
    .WIN(8)
  ) u_streak (
    .i_mclk      (I_MCLK),
    .i_nrst      (I_NRST),
    .i_valid     (q.adj_v),
    .i_pix       (q.adj),
    .i_white_lvl (q.streak_reg[WHITE_LVL_LSB +: 2]),
    .i_black_lvl (q.streak_reg[BLACK_LVL_LSB +: 2]),
    .o_valid     (O_PIX_VALID),
    .o_pix       (O_PIX)
  );

  // Outputs
  assign O_RDATA      = q.rdata;
  assign O_IRQ        = |(q.status & q.mask);
  assign O_BG_LEVEL   = q.bg;
  assign O_LAMP_FAULT = (q.st == ST_FAULT);

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_NRST);

  a_black_ref_avg: assert property (
    q.s2_v && !q.s2_l && q.cnt == DUM_END - 1'b1 |=> q.black == 8'($past(acc_new) >> DUMMY_SHIFT))
    else $error("black reference is not the dummy pixel average");

  a_norm_top_code: assert property (
    q.st == ST_SCAN && q.s2_v && in_img && pix6 != 6'h00 && pix6 == q.white[idx]
    |=> q.norm_v && q.norm == PIX_TOP)
    else $error("reference white does not map to the top code");

  a_shade_ok_ready: assert property (
    shade_end && q.shade_peak > LAMP_MIN_PEAK && !I_WR
    |=> q.st == ST_READY && q.status[ST_SHADE_DONE])
    else $error("good shading did not reach ready");

  a_lamp_fault_raise: assert property (
    shade_end && q.shade_peak <= LAMP_MIN_PEAK && !I_WR
    |=> O_LAMP_FAULT && q.status[ST_LAMP] ##1 O_LAMP_FAULT)
    else $error("low white peak did not raise the lamp fault");

  a_page_reshade: assert property (
    q.st == ST_SCAN && I_WR && I_ADDR == REG_CTRL && I_WDATA[CTRL_PAGE_DONE] && !I_WDATA[CTRL_JOB_END]
    |=> q.st == ST_SHADE && q.shade_lines == '0 && !q.armed)
    else $error("end of page did not start shading");

  a_mode_reshade: assert property (
    q.st == ST_READY && I_WR && I_ADDR == REG_MODE && I_WDATA != q.mode_reg
    |=> q.st == ST_SHADE && q.shade_peak == 8'h00)
    else $error("mode change did not start shading");

  a_bg_peak_track: assert property (
    q.norm_v && q.norm_eol
    |=> q.bg == (($past(q.norm) > $past(q.line_peak)) ? $past(q.norm) : $past(q.line_peak)) && q.line_peak == 6'h00)
    else $error("background level is not the line peak");

  a_ads_mode_gate: assert property (
    q.norm_v && !ssle_ads_mode(q.mode_reg[MODE_LSB +: 4])
    |=> q.adj_v && q.adj == ssle_density($past(q.norm), $past(q.mode_reg[DENS_LSB +: 3])))
    else $error("background tracking active outside text modes");

  a_status_read_clr: assert property (
    I_RD && I_ADDR == REG_STATUS && ev == 8'h00 |=> q.status == 8'h00 && !O_IRQ)
    else $error("status read did not clear");

  a_status_set_wins: assert property (
    ev != 8'h00 |=> (q.status & $past(ev)) == $past(ev))
    else $error("status event lost to a clearing read");

  a_fault_holds: assert property (
    q.st == ST_FAULT && !(I_WR && I_ADDR == REG_CTRL && (I_WDATA[CTRL_JOB_START] || I_WDATA[CTRL_JOB_END]))
    |=> O_LAMP_FAULT)
    else $error("lamp fault left without a new job");

  a_scan_only_out: assert property (
    q.st != ST_SCAN |=> !q.norm_v)
    else $error("image output outside a page scan");

  a_shade_line_cap: assert property (
    q.st == ST_SHADE |-> q.shade_lines <= SHADE_END)
    else $error("shading line count overran");

  a_white_corr_all: assert property (
    q.st == ST_SCAN && q.s2_v && in_img |=> q.norm_v)
    else $error("image pixel skipped white correction");

endmodule

// File: logic/ssle_streak_filter.sv
// Thin white and black streak eraser on the 6-bit pixel stream.
// Assumes pixels arrive with a valid strobe; output lags by eight pixels.
`timescale 1ns/1ps
module ssle_streak_filter import ssle_pkg::*; #(
  parameter int WIN = 8
) (
  input  wire logic       i_mclk,
  input  wire logic       i_nrst,
  input  wire logic       i_valid,
  input  wire logic [5:0] i_pix,
  input  wire logic [1:0] i_white_lvl,
  input  wire logic [1:0] i_black_lvl,
  output logic            o_valid,
  output logic [5:0]      o_pix
);

  typedef struct packed {
    logic [WIN-1:0][5:0] win;
    logic [2:0]          fill;
    logic                ov;
    logic [5:0]          opix;
  } ssle_flt_t;

  ssle_flt_t           q;
  ssle_flt_t           next_q;
  logic [WIN-1:0][5:0] w;
  logic                found;
  logic                hit;
  logic [6:0]          edge_hi;
  logic [6:0]          edge_lo;
  logic [5:0]          fillv;
  logic [5:0]          wthr;
  logic [5:0]          bthr;
  int                  bmax;

  generate
    if (WIN != 8) begin : g_chk
      $error("ssle_streak_filter needs an eight pixel window");
    end
  endgenerate

  // Shift, find one bounded streak, patch it from its edges
  always_comb begin
    next_q = q;
    w = '0;
    found = 1'b0;
    hit = 1'b0;
    edge_hi = '0;
    edge_lo = '0;
    fillv = '0;
    wthr = (i_white_lvl == 2'h1) ? WHITE_THR1 : WHITE_THR2;
    bthr = (i_black_lvl == 2'h1) ? BLACK_THR1 : (i_black_lvl == 2'h2) ? BLACK_THR2 : BLACK_THR3;
    bmax = (i_black_lvl == 2'h3) ? BLACK_MAX_W3 : BLACK_MAX_W12;
    next_q.ov = 1'b0;
    if (i_valid) begin
      w = {q.win[WIN-2:0], i_pix};
      for (int len = 1; len <= WHITE_MAX_W; len++) begin
        edge_hi = (w[0] > w[len+1]) ? 7'(w[0]) : 7'(w[len+1]);
        edge_lo = (w[0] < w[len+1]) ? 7'(w[0]) : 7'(w[len+1]);
        fillv = 6'((7'(w[0]) + 7'(w[len+1])) >> 1);
        // White streak: every pixel far lighter than both edges
        hit = (i_white_lvl != 2'h0) && !found;
        for (int k = 1; k <= WHITE_MAX_W; k++) begin
          if (k <= len && 7'(w[k]) <= edge_hi + 7'(wthr)) hit = 1'b0;
        end
        if (!hit && i_black_lvl != 2'h0 && !found && len <= bmax) begin
          hit = 1'b1;
          for (int k = 1; k <= BLACK_MAX_W3; k++) begin
            if (k <= len && 7'(w[k]) + 7'(bthr) >= edge_lo) hit = 1'b0;
          end
        end
        if (hit) begin
          found = 1'b1;
          for (int k = 1; k <= WHITE_MAX_W; k++) begin
            if (k <= len) w[k] = fillv;
          end
        end
      end
      next_q.win = w;
      next_q.fill = (q.fill == 3'h7) ? q.fill : q.fill + 3'h1;
      next_q.ov = (q.fill == 3'h7);
      next_q.opix = q.win[WIN-1];
    end
  end

  // State register
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign o_valid = q.ov;
  assign o_pix   = q.opix;

endmodule

// File: verification/ssle_sensor_model.sv
// Sensor-side model: digitised line stream with dummies, sync and pixels.
// Assumes the bench calls send_line; drives on rising edges only.
`timescale 1ns/1ps
module ssle_sensor_model (
  input  wire logic       i_mclk,
  output logic            o_valid,
  output logic            o_sync,
  output logic      [7:0] o_pix
);
  // Idle line after time zero
  initial begin
    o_valid = 1'b0;
    o_sync  = 1'b0;
    o_pix   = 8'h00;
  end

  // One line: 32 dummies around blk, then 8 image bytes, byte 0 first
  task automatic send_line(input logic [7:0] blk, input logic [63:0] img);
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge i_mclk);
      o_valid <= 1'b1;
      o_sync  <= (i == 0);
      if (i >= 32) begin
        o_pix <= img[(i-32)*8 +: 8];
      end else if (i % 2 == 1) begin
        o_pix <= blk + 8'h04;
      end else begin
        o_pix <= blk - 8'h04;
      end
    end
    // Released data shows the inverse, not a stale pixel
    @(posedge i_mclk);
    o_valid <= 1'b0;
    o_sync  <= 1'b0;
    o_pix   <= ~o_pix;
    repeat (4) @(posedge i_mclk);
  endtask
endmodule

// File: verification/tb.sv
// Self-checking bench for the shading and streak erase stage.
// Assumes an 8-pixel line and one shading line for short runs.
`timescale 1ns/1ps
module tb;
  import ssle_pkg::*;
  logic       I_MCLK, I_NRST, I_PIX_VALID, I_LINE_SYNC, I_WR, I_RD;
  logic [7:0] I_PIX, I_WDATA, O_RDATA, rd_val;
  logic [3:0] I_ADDR;
  logic       O_IRQ, O_PIX_VALID, O_LAMP_FAULT;
  logic [5:0] O_PIX, O_BG_LEVEL;
  logic [5:0] outq[$];
  int         bad_count, total_checks;
  // Level codes: dark, grey, flat, light, white
  logic [7:0] raw_lut [5] = '{8'h10, 8'h28, 8'h50, 8'h68, 8'h90};
  logic [5:0] out_lut [5] = '{6'h00, 6'h0b, 6'h1f, 6'h2b, 6'h3f};
  logic [1:0] wl [10] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
  logic [1:0] bl [10] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h3, 2'h1, 2'h2};
  logic [31:0] img [10] = '{32'h20242222, 32'h22244222, 32'h24444444, 32'h22232222, 32'h22232222,
                            32'h20000222, 32'h20000022, 32'h20000022, 32'h22212222, 32'h22212222};
  logic [31:0] want [10] = '{32'h20242222, 32'h22222222, 32'h24444444, 32'h22232222, 32'h22222222,
                             32'h22222222, 32'h20000022, 32'h22222222, 32'h22212222, 32'h22222222};

  ssle_shading_top #(.LINE_PIX(8), .SHADE_LINES(1)) dut (
    .I_MCLK(I_MCLK), .I_NRST(I_NRST), .I_PIX_VALID(I_PIX_VALID), .I_LINE_SYNC(I_LINE_SYNC),
    .I_PIX(I_PIX), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
    .O_RDATA(O_RDATA), .O_IRQ(O_IRQ), .O_PIX_VALID(O_PIX_VALID), .O_PIX(O_PIX),
    .O_BG_LEVEL(O_BG_LEVEL), .O_LAMP_FAULT(O_LAMP_FAULT));

  ssle_sensor_model sens (
    .i_mclk(I_MCLK), .o_valid(I_PIX_VALID), .o_sync(I_LINE_SYNC), .o_pix(I_PIX));

  // 125 MHz clock
  always #4 I_MCLK = ~I_MCLK;

  // Collect output pixels away from the launching edge
  always @(negedge I_MCLK) begin
    if (O_PIX_VALID === 1'b1) outq.push_back(O_PIX);
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp_v);
    total_checks++;
    if (seen !== exp_v) begin
      bad_count++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp_v);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge I_MCLK);
    I_WR    <= 1'b1;
    I_ADDR  <= a;
    I_WDATA <= d;
    @(posedge I_MCLK);
    I_WR    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge I_MCLK);
    I_RD   <= 1'b1;
    I_ADDR <= a;
    @(posedge I_MCLK);
    I_RD   <= 1'b0;
    @(negedge I_MCLK);
    d = O_RDATA;
  endtask

  // Two white plate lines; the first may only arm the sequence
  task automatic shade(input logic [7:0] w);
    sens.send_line(8'h10, {8{w}});
    sens.send_line(8'h10, {8{w}});
    repeat (4) @(posedge I_MCLK);
  endtask

  task automatic test_reset;
    rd(REG_MODE, rd_val);   check(rd_val, 8'hc0);
    rd(REG_STREAK, rd_val); check(rd_val, 8'h05);
    rd(REG_MASK, rd_val);   check(rd_val, 8'h00);
    rd(REG_STATUS, rd_val); check(rd_val, 8'h00);
    rd(REG_STATE, rd_val);  check(rd_val, 8'h00);
    rd(4'hf, rd_val);       check(rd_val, 8'h00);
    check({7'h00, O_IRQ}, 8'h00);
    check({7'h00, O_LAMP_FAULT}, 8'h00);
    $display("test_reset done");
  endtask

  // White peak of exactly 64 after black removal
  task automatic test_lamp;
    wr(REG_MODE, 8'h40);
    wr(REG_MASK, 8'h02);
    wr(REG_CTRL, 8'h01);
    shade(8'h50);
    rd(REG_STATE, rd_val); check(rd_val, 8'h04);
    rd(REG_PEAK, rd_val);  check(rd_val, 8'h40);
    check({7'h00, O_LAMP_FAULT}, 8'h01);
    check({7'h00, O_IRQ}, 8'h01);
    rd(REG_STATUS, rd_val); check(rd_val & 8'h02, 8'h02);
    check({7'h00, O_IRQ}, 8'h00);
    $display("test_lamp done");
  endtask

  task automatic test_shade_ok;
    wr(REG_CTRL, 8'h01);
    shade(8'h90);
    rd(REG_STATE, rd_val); check(rd_val, 8'h02);
    check({7'h00, O_LAMP_FAULT}, 8'h00);
    check({7'h00, O_IRQ}, 8'h00);
    rd(REG_STATUS, rd_val); check(rd_val & 8'h01, 8'h01);
    rd(REG_BLACK, rd_val);  check(rd_val, 8'h10);
    $display("test_shade_ok done");
  endtask

  // One page per table row, then the between-page shading
  task automatic test_streaks;
    logic [63:0] line;
    int r, k, n;
    for (r = 0; r < 10; r++) begin
      wr(REG_STREAK, {4'h0, bl[r], wl[r]});
      outq.delete();
      wr(REG_CTRL, 8'h02);
      rd(REG_STATE, rd_val); check(rd_val, 8'h03);
      for (k = 0; k < 8; k++) line[k*8 +: 8] = raw_lut[img[r][31-4*k -: 4]];
      sens.send_line(8'h10, line);
      sens.send_line(8'h10, {8{8'h50}});
      repeat (24) @(posedge I_MCLK);
      n = outq.size();
      check(8'(n >= 8), 8'h01);
      for (k = 0; k < 8 && n >= 8; k++) begin
        check({2'b00, outq[n-8+k]}, {2'b00, out_lut[want[r][31-4*k -: 4]]});
      end
      wr(REG_CTRL, 8'h04);
      rd(REG_STATE, rd_val); check(rd_val, 8'h01);
      shade(8'h90);
      rd(REG_STATE, rd_val); check(rd_val, 8'h02);
    end
    $display("test_streaks done");
  endtask

  task automatic test_restart;
    wr(REG_MODE, 8'h41);
    rd(REG_STATE, rd_val); check(rd_val, 8'h01);
    shade(8'h90);
    rd(REG_STATE, rd_val); check(rd_val, 8'h02);
    $display("test_restart done");
  endtask

  // One page of flat, grey, flat lines; the middle line is judged
  task automatic ads_page(input logic [5:0] exp_v);
    int k, n;
    wr(REG_CTRL, 8'h02);
    outq.delete();
    sens.send_line(8'h10, {8{8'h50}});
    sens.send_line(8'h10, {8{8'h28}});
    @(negedge I_MCLK);
    check({2'b00, O_BG_LEVEL}, 8'h0b);
    sens.send_line(8'h10, {8{8'h50}});
    repeat (24) @(posedge I_MCLK);
    n = outq.size();
    check(8'(n >= 8), 8'h01);
    for (k = 0; k < 8 && n >= 8; k++) begin
      check({2'b00, outq[n-8+k]}, {2'b00, exp_v});
    end
    @(negedge I_MCLK);
    check({2'b00, O_BG_LEVEL}, 8'h1f);
    wr(REG_CTRL, 8'h04);
    shade(8'h90);
  endtask

  // Background tracking with manual density, then outside the text modes
  task automatic test_ads;
    wr(REG_STREAK, 8'h00);
    wr(REG_MODE, 8'he0);
    rd(REG_STATE, rd_val); check(rd_val, 8'h01);
    shade(8'h90);
    ads_page(6'h18);
    rd(REG_STATUS, rd_val); check(rd_val & 8'h04, 8'h04);
    wr(REG_MODE, 8'he2);
    shade(8'h90);
    ads_page(6'h0d);
    rd(REG_BG, rd_val); check(rd_val, 8'h1f);
    wr(REG_CTRL, 8'h08);
    rd(REG_STATE, rd_val); check(rd_val, 8'h00);
    $display("test_ads done");
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    I_MCLK = 1'b0;
    I_NRST = 1'b0;
    I_ADDR = 4'h0;
    I_WDATA = 8'h00;
    I_WR = 1'b0;
    I_RD = 1'b0;
    bad_count = 0;
    total_checks = 0;
    repeat (6) @(posedge I_MCLK);
    I_NRST <= 1'b1;
    test_reset;
    test_lamp;
    test_shade_ok;
    test_streaks;
    test_restart;
    test_ads;
    end_of_test;
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge I_MCLK);
    bad_count++;
    end_of_test;
  end
endmodule
